// >>> rtl/intc_regs.svh
// Purpose: Register map, field positions and reset values of the priority controller
// Assumes: Included by bare name from the priority controller files
// Notes:   Definitions only
`ifndef INTC_REGS_SVH
`define INTC_REGS_SVH

// ==========================================================================
// Register offsets
`define ADDR_SERIAL_PRIO   8'h00
`define ADDR_CAN_DMA_PRIO  8'h02
`define ADDR_PEND_STATUS   8'h04
`define ADDR_INT_CTRL_ONE  8'h06
`define ADDR_FLAGS         8'h08
`define ADDR_FLAG_CLEAR    8'h0A
`define ADDR_ENABLES       8'h0C
`define ADDR_STATUS_LOW    8'h0E
`define ADDR_TIMED_DIS     8'h10

// ==========================================================================
// Reset values and implemented-bit masks
`define RST_SERIAL_PRIO    16'h0440
`define MASK_SERIAL_PRIO   16'h0770
`define RST_CAN_DMA_PRIO   16'h4444
`define MASK_CAN_DMA_PRIO  16'h7777
`define RST_ZERO16         16'h0000
`define MASK_INT_CTRL_ONE  16'h800F

// ==========================================================================
// Field positions
`define SER1_PRIO_LO       4
`define SER2_PRIO_LO       8
`define DMA6_PRIO_LO       0
`define DMA7_PRIO_LO       4
`define CAN1_PRIO_LO       8
`define CAN2_PRIO_LO       12
`define NEST_DIS_BIT       15
`define SRL_LVL_LO         1
`define STATUS_LVL_LO      8

// ==========================================================================
// Sizes and levels
`define NUM_TRAPS          4
`define NUM_USERS          6
`define NUM_SRC            10
`define STACK_DEPTH        8
`define USER_TOP_LEVEL     4'h7
`define TRAP_LEVELS        16'hECA8
`define DIS_CNT_W          14
`define STACK_AW           4

`endif

// >>> rtl/intc_pkg.sv
// Purpose: Types shared by the priority controller
// Assumes: Nothing beyond the register header
// Notes:   Status word layout carried as a packed struct
package intc_pkg;

  typedef logic [2:0] prio_t;
  typedef logic [3:0] level_t;
  typedef logic [6:0] vec_t;

  // ==========================================================================
  // Pending vector status word
  typedef struct packed {
    logic [3:0] zero_hi;
    level_t     new_cpu_level;
    logic       zero_mid;
    vec_t       pending_vector_index;
  } pend_status_t;

  // ==========================================================================
  // Register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

endpackage

// >>> rtl/priority_interrupt_controller.sv
// Purpose: Priority arbitration, level tracking and status of a vectored interrupt controller
// Assumes: Source and trap events are one-cycle pulses on clk; CPU ack/return are pulses
// Notes:   Vector codes: traps 0-3, then serial1, serial2, dma6, dma7, can1, can2
`timescale 1ns/10ps
`include "intc_regs.svh"

// Overview of operation
// RULE1: Each source has a three-bit priority; seven highest, one lowest.
// RULE2: Priority zero disables the source; it never requests.
// RULE3: Reset sets every user source priority to level four.
// RULE4: Status bits 11..8 give the new CPU level, 0 to 15.
// RULE5: Status bits 6..0 give the pending vector number minus eight.
// RULE6: Nesting-disable bit 15 of control register one blocks nested interrupts. Here it blocks only levels up to seven, so traps still nest.
// RULE7: Pending flags stay set until software clears them; uncleared flags re-request.
// RULE8: Only sources whose enable bit is set may request service.
// RULE9: Return from interrupt restores the previous CPU level from the stack.
// RULE10: Each trap has a sticky flag in control register one; software clears it.
// RULE11: CPU level seven, via status low byte OR 0x0E, masks all user interrupts.
// RULE12: Traps at levels 8 to 15 are never masked by user CPU level.
// RULE13: Timed disable masks levels one to six; level seven stays open.
// RULE14: Software may give all enabled sources one equal non-zero priority.
// RULE15: Unimplemented bits of priority and status registers read as zero.
// RULE16: Serial priority register: serial2 at bits 10..8, serial1 at 6..4.
// RULE17: CAN/DMA register: can2 14..12, can1 10..8, dma7 6..4, dma6 2..0.
// RULE18: Highest priority above CPU level wins; ties go to the lowest vector.
// RULE19: Priority fields are software read/write; new values used next arbitration.
module priority_interrupt_controller
  import intc_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  srst,
  input  wire logic [7:0]            reg_addr,
  input  wire logic [15:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [15:0]           reg_rdata,
  input  wire logic [`NUM_USERS-1:0] src_event,
  input  wire logic [`NUM_TRAPS-1:0] trap_event,
  input  wire logic                  cpu_ack,
  input  wire logic                  cpu_return,
  output logic                       irq_req,
  output vec_t                       irq_vector,
  output level_t                     irq_level,
  output level_t                     cpu_level,
  output logic                       intr
);

  // ==========================================================================
  // Registers
  reg_req_t                 req;
  logic [15:0]              serial_prio_ff;
  logic [15:0]              can_prio_ff;
  logic [15:0]              ctrl_one_ff;
  logic [`NUM_USERS-1:0]    flag_ff;
  logic [`NUM_USERS-1:0]    en_ff;
  level_t                   cpu_level_ff;
  level_t                   stack_ff [`STACK_DEPTH];
  logic [`STACK_AW-1:0]     depth_ff;
  logic [`DIS_CNT_W-1:0]    dis_cnt_ff;
  logic                     irq_req_ff;
  vec_t                     irq_vector_ff;
  level_t                   irq_level_ff;
  logic [15:0]              reg_rdata_ff;
  logic                     intr_ff;
  pend_status_t             pend_status;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // ==========================================================================
  // Priority registers
  always_ff @(posedge clk) begin
    if (srst) begin
      serial_prio_ff <= `RST_SERIAL_PRIO; // RULE3
      can_prio_ff    <= `RST_CAN_DMA_PRIO; // RULE3
    end else if (req.wr && req.addr == `ADDR_SERIAL_PRIO) begin
      serial_prio_ff <= req.wdata & `MASK_SERIAL_PRIO; // RULE19 RULE15
    end else if (req.wr && req.addr == `ADDR_CAN_DMA_PRIO) begin
      can_prio_ff <= req.wdata & `MASK_CAN_DMA_PRIO; // RULE19 RULE15
    end
  end

  // ==========================================================================
  // Per-source priorities and candidates
  prio_t                 user_prio [`NUM_USERS];
  level_t                cand_level [`NUM_SRC];
  logic [`NUM_SRC-1:0]   cand_ok;
  level_t                thr;
  logic                  nest_block;
  logic                  timed_mask;

  assign user_prio[0] = serial_prio_ff[`SER1_PRIO_LO +: 3]; // RULE16
  assign user_prio[1] = serial_prio_ff[`SER2_PRIO_LO +: 3]; // RULE16
  assign user_prio[2] = can_prio_ff[`DMA6_PRIO_LO +: 3]; // RULE17
  assign user_prio[3] = can_prio_ff[`DMA7_PRIO_LO +: 3]; // RULE17
  assign user_prio[4] = can_prio_ff[`CAN1_PRIO_LO +: 3]; // RULE17
  assign user_prio[5] = can_prio_ff[`CAN2_PRIO_LO +: 3]; // RULE17

  // Nesting disable lifts the threshold to seven while any handler runs
  assign nest_block = ctrl_one_ff[`NEST_DIS_BIT] && (depth_ff != '0); // RULE6
  assign timed_mask = (dis_cnt_ff != '0);
  assign thr = (nest_block && cpu_level_ff < `USER_TOP_LEVEL) ? `USER_TOP_LEVEL
                                                              : cpu_level_ff;

  genvar gi;
  generate
    for (gi = 0; gi < `NUM_SRC; gi++) begin : g_cand
      if (gi < `NUM_TRAPS) begin : g_trap
        // Trap levels sit above every user level, so user masking never hides them
        assign cand_level[gi] = level_t'(`TRAP_LEVELS >> (4 * gi)); // RULE12
        assign cand_ok[gi]    = ctrl_one_ff[gi] && (cand_level[gi] > thr); // RULE10 RULE12
      end else begin : g_user
        assign cand_level[gi] = {1'b0, user_prio[gi - `NUM_TRAPS]}; // RULE1
        assign cand_ok[gi]    = flag_ff[gi - `NUM_TRAPS] && en_ff[gi - `NUM_TRAPS] // RULE7 RULE8
                                && (user_prio[gi - `NUM_TRAPS] != 3'h0) // RULE2
                                && (cand_level[gi] > thr) // RULE11
                                && !(timed_mask && cand_level[gi] < `USER_TOP_LEVEL); // RULE13
      end
    end
  endgenerate

  // ==========================================================================
  // Arbitration: strict greater keeps the lowest vector on a tie
  logic   win_valid;
  vec_t   win_vec;
  level_t win_level;

  always_comb begin
    win_valid = 1'b0;
    win_vec   = '0;
    win_level = '0;
    for (int i = 0; i < `NUM_SRC; i++) begin
      if (cand_ok[i] && (!win_valid || cand_level[i] > win_level)) begin // RULE18
        win_valid = 1'b1;
        win_vec   = vec_t'(i);
        win_level = cand_level[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      irq_req_ff    <= 1'b0;
      irq_vector_ff <= '0;
      irq_level_ff  <= '0;
    end else begin
      irq_req_ff    <= win_valid; // RULE18
      irq_vector_ff <= win_vec; // RULE5
      irq_level_ff  <= win_level; // RULE4
    end
  end

  // ==========================================================================
  // Control register one: nesting disable and sticky trap flags
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_one_ff <= `RST_ZERO16;
    end else begin
      if (req.wr && req.addr == `ADDR_INT_CTRL_ONE) begin
        ctrl_one_ff <= (req.wdata & `MASK_INT_CTRL_ONE)
                       | {12'h000, trap_event}; // RULE6 RULE10
      end else begin
        ctrl_one_ff[`NUM_TRAPS-1:0] <= ctrl_one_ff[`NUM_TRAPS-1:0] | trap_event; // RULE10
      end
    end
  end

  // ==========================================================================
  // Source flags and enables; a new event beats a clear in the same cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      flag_ff <= '0;
    end else if (req.wr && req.addr == `ADDR_FLAG_CLEAR) begin
      flag_ff <= (flag_ff & ~req.wdata[`NUM_USERS-1:0]) | src_event; // RULE7
    end else begin
      flag_ff <= flag_ff | src_event; // RULE7
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      en_ff <= '0;
    end else if (req.wr && req.addr == `ADDR_ENABLES) begin
      en_ff <= req.wdata[`NUM_USERS-1:0]; // RULE8
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      intr_ff <= 1'b0;
    end else begin
      intr_ff <= |(flag_ff & en_ff);
    end
  end

  // ==========================================================================
  // CPU level and saved-level stack
  always_ff @(posedge clk) begin
    if (srst) begin
      cpu_level_ff <= '0;
      depth_ff     <= '0;
    end else if (cpu_ack && irq_req_ff) begin
      cpu_level_ff <= irq_level_ff;
      // A full stack still raises the level but keeps no more history
      if (depth_ff != `STACK_AW'(`STACK_DEPTH)) begin
        depth_ff <= depth_ff + `STACK_AW'(1);
      end
    end else if (cpu_return && depth_ff != '0) begin
      cpu_level_ff <= stack_ff[depth_ff[2:0] - 3'h1]; // RULE9
      depth_ff     <= depth_ff - `STACK_AW'(1); // RULE9
    end else if (req.wr && req.addr == `ADDR_STATUS_LOW) begin
      cpu_level_ff <= {1'b0, req.wdata[`SRL_LVL_LO +: 3]}; // RULE11
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < `STACK_DEPTH; i++) begin
        stack_ff[i] <= '0;
      end
    end else if (cpu_ack && irq_req_ff && depth_ff != `STACK_AW'(`STACK_DEPTH)) begin
      stack_ff[depth_ff[2:0]] <= cpu_level_ff; // RULE9
    end
  end

  // ==========================================================================
  // Timed disable counter
  always_ff @(posedge clk) begin
    if (srst) begin
      dis_cnt_ff <= '0;
    end else if (req.wr && req.addr == `ADDR_TIMED_DIS) begin
      dis_cnt_ff <= req.wdata[`DIS_CNT_W-1:0]; // RULE13
    end else if (dis_cnt_ff != '0) begin
      dis_cnt_ff <= dis_cnt_ff - `DIS_CNT_W'(1); // RULE13
    end
  end

  // ==========================================================================
  // Read path; unmapped and write-only offsets read zero
  assign pend_status = '{zero_hi: 4'h0, new_cpu_level: irq_level_ff, zero_mid: 1'b0,
                         pending_vector_index: irq_vector_ff}; // RULE4 RULE5 RULE15

  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata_ff <= `RST_ZERO16;
    end else if (req.rd) begin
      if (req.addr == `ADDR_SERIAL_PRIO) begin
        reg_rdata_ff <= serial_prio_ff;
      end else if (req.addr == `ADDR_CAN_DMA_PRIO) begin
        reg_rdata_ff <= can_prio_ff;
      end else if (req.addr == `ADDR_PEND_STATUS) begin
        reg_rdata_ff <= pend_status;
      end else if (req.addr == `ADDR_INT_CTRL_ONE) begin
        reg_rdata_ff <= ctrl_one_ff;
      end else if (req.addr == `ADDR_FLAGS) begin
        reg_rdata_ff <= {10'h000, flag_ff};
      end else if (req.addr == `ADDR_ENABLES) begin
        reg_rdata_ff <= {10'h000, en_ff};
      end else if (req.addr == `ADDR_STATUS_LOW) begin
        reg_rdata_ff <= {12'h000, cpu_level_ff[2:0], 1'b0};
      end else if (req.addr == `ADDR_TIMED_DIS) begin
        reg_rdata_ff <= {2'h0, dis_cnt_ff};
      end else begin
        reg_rdata_ff <= `RST_ZERO16;
      end
    end else begin
      reg_rdata_ff <= `RST_ZERO16;
    end
  end

  assign reg_rdata  = reg_rdata_ff;
  assign irq_req    = irq_req_ff;
  assign irq_vector = irq_vector_ff;
  assign irq_level  = irq_level_ff;
  assign cpu_level  = cpu_level_ff;
  assign intr       = intr_ff;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  zero_prio_a: assert property (irq_req_ff |-> irq_level_ff != 4'h0) // RULE2
    else $error("request raised at level zero");
  reset_prio_a: assert property ($fell(srst) |->
      serial_prio_ff == `RST_SERIAL_PRIO && can_prio_ff == `RST_CAN_DMA_PRIO) // RULE3
    else $error("priorities not level four after reset");
  above_level_a: assert property (irq_req_ff |-> irq_level_ff > $past(thr)) // RULE18
    else $error("winner not above cpu level");
  status_fmt_a: assert property (reg_rd && reg_addr == `ADDR_PEND_STATUS |=>
      reg_rdata_ff == {4'h0, $past(irq_level_ff), 1'b0, $past(irq_vector_ff)}) // RULE4
    else $error("pending status word wrong");
  nest_block_a: assert property ($past(nest_block) && irq_req_ff |->
      irq_level_ff > `USER_TOP_LEVEL) // RULE6
    else $error("nested user interrupt while nesting disabled");
  flag_hold_a: assert property (!(reg_wr && reg_addr == `ADDR_FLAG_CLEAR) |=>
      (flag_ff & $past(flag_ff)) == $past(flag_ff)) // RULE7
    else $error("source flag lost without clear");
  enable_gate_a: assert property (irq_req_ff && irq_vector_ff >= 7'h04 |->
      $past(flag_ff & en_ff) != '0) // RULE8
    else $error("user request without enabled flag");
  rfi_restore_a: assert property (cpu_return && !cpu_ack && depth_ff != '0 |=>
      cpu_level_ff == $past(stack_ff[depth_ff[2:0] - 3'h1])) // RULE9
    else $error("level not restored on return");
  trap_sticky_a: assert property (!(reg_wr && reg_addr == `ADDR_INT_CTRL_ONE) |=>
      (ctrl_one_ff[3:0] & $past(ctrl_one_ff[3:0])) == $past(ctrl_one_ff[3:0])) // RULE10
    else $error("trap flag lost without clear");
  trap_open_a: assert property (ctrl_one_ff[3] && cpu_level_ff < 4'hE |=> irq_req_ff) // RULE12
    else $error("trap masked by cpu level");
  mask_seven_a: assert property ($past(cpu_level_ff) == 4'h7 && irq_req_ff |->
      irq_level_ff >= 4'h8) // RULE11
    else $error("user interrupt passed level seven");
  timed_dis_a: assert property ($past(timed_mask) && irq_req_ff |->
      irq_level_ff >= `USER_TOP_LEVEL) // RULE13
    else $error("level below seven during timed disable");
  field_write_a: assert property (reg_wr && reg_addr == `ADDR_CAN_DMA_PRIO |=>
      can_prio_ff == ($past(reg_wdata) & `MASK_CAN_DMA_PRIO)) // RULE17
    else $error("priority write not applied");

  // ==========================================================================
  // Read-back and masking guards
  // Serial field writes must land masked, so reserved bits can never be set
  serial_write_a: assert property (reg_wr && reg_addr == `ADDR_SERIAL_PRIO |=>
      serial_prio_ff == ($past(reg_wdata) & `MASK_SERIAL_PRIO)) // RULE16
    else $error("serial priority write not applied");
  unimpl_zero_a: assert property (reg_rd && reg_addr == `ADDR_SERIAL_PRIO |=>
      (reg_rdata_ff & ~`MASK_SERIAL_PRIO) == `RST_ZERO16) // RULE15
    else $error("unimplemented serial bits read non-zero");
  status_low_a: assert property (reg_rd && reg_addr == `ADDR_STATUS_LOW |=>
      reg_rdata_ff == {12'h000, $past(cpu_level_ff[2:0]), 1'b0}) // RULE11
    else $error("status low byte read-back wrong");
  // Timed disable must leave a pending level-seven source visible
  seven_open_a: assert property (timed_mask && flag_ff[1] && en_ff[1]
      && user_prio[1] == 3'h7 && cpu_level_ff < `USER_TOP_LEVEL && !nest_block
      |=> irq_req_ff && irq_level_ff >= `USER_TOP_LEVEL) // RULE13
    else $error("level seven hidden by timed disable");

  ack_c: cover property (irq_req_ff && cpu_ack ##[1:20] cpu_return);
  nest_c: cover property (irq_req_ff && cpu_ack ##[1:20] irq_req_ff && cpu_ack);
  trap_c: cover property (irq_req_ff && irq_vector_ff < 7'h04);
  timed_c: cover property (timed_mask && irq_req_ff && irq_level_ff == 4'h7);
  trap_top_c: cover property (irq_req_ff && irq_vector_ff == 7'h03);

endmodule

// >>> tb/cpu_model.sv
// Purpose: CPU-side partner that takes interrupt requests and returns from them
// Assumes: Shares clk with the controller; srst synchronous, active high
// Notes:   lat sets the take delay so prompt and slow takes both occur
`timescale 1ns/10ps
module cpu_model (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       irq_req,
  input  wire logic       take,
  input  wire logic       ret_go,
  input  wire logic [3:0] lat,
  output logic            cpu_ack,
  output logic            cpu_return
);
  logic       armed_ff;
  logic [3:0] cnt_ff;

  // ==========================================================================
  // One ack per take, so a standing request is never taken twice
  always_ff @(posedge clk) begin
    if (srst) begin
      armed_ff   <= 1'b0;
      cnt_ff     <= 4'h0;
      cpu_ack    <= 1'b0;
      cpu_return <= 1'b0;
    end else begin
      cpu_ack    <= 1'b0;
      cpu_return <= ret_go;
      if (take) begin
        armed_ff <= 1'b1;
        cnt_ff   <= 4'h0;
      end else if (armed_ff && irq_req) begin
        if (cnt_ff == lat) begin
          cpu_ack  <= 1'b1;
          armed_ff <= 1'b0;
        end else begin
          cnt_ff <= cnt_ff + 4'h1;
        end
      end
    end
  end
endmodule

// >>> tb/tb.sv
// Purpose: Self-checking bench of the priority interrupt controller
// Assumes: Design and CPU model share clk; srst synchronous, active high
// Notes:   Request outputs are judged two cycles after their cause
`timescale 1ns/10ps
module tb
  import intc_pkg::*;
();
  logic        clk;
  logic        srst       = 1'b1;
  logic [7:0]  reg_addr   = 8'h00;
  logic [15:0] reg_wdata  = 16'h0000;
  logic        reg_wr     = 1'b0;
  logic        reg_rd     = 1'b0;
  logic [5:0]  src_event  = 6'h00;
  logic [3:0]  trap_event = 4'h0;
  logic        take       = 1'b0;
  logic        ret_go     = 1'b0;
  logic [3:0]  lat        = 4'h0;
  logic [15:0] reg_rdata;
  logic        cpu_ack;
  logic        cpu_return;
  logic        irq_req;
  vec_t        irq_vector;
  level_t      irq_level;
  level_t      cpu_level;
  logic        intr;
  int          num_errors = 0;
  int          num_checks = 0;
  int          cyc        = 0;

  priority_interrupt_controller u_dut (
    .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_event(src_event),
    .trap_event(trap_event), .cpu_ack(cpu_ack), .cpu_return(cpu_return),
    .irq_req(irq_req), .irq_vector(irq_vector), .irq_level(irq_level),
    .cpu_level(cpu_level), .intr(intr)
  );

  cpu_model u_cpu (
    .clk(clk), .srst(srst), .irq_req(irq_req), .take(take), .ret_go(ret_go),
    .lat(lat), .cpu_ack(cpu_ack), .cpu_return(cpu_return)
  );

  // ==========================================================================
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      num_errors++;
      stop_test();
    end
  end

  // ==========================================================================
  // Shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Reads compare against d in the single cycle the data stands
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr    <= w;
    reg_rd    <= !w;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    if (!w) begin
      #1 chk(reg_rdata, d);
    end
  endtask

  task automatic pulse(input logic [5:0] s, input logic [3:0] t);
    @(posedge clk);
    src_event  <= s;
    trap_event <= t;
    @(posedge clk);
    src_event  <= 6'h00;
    trap_event <= 4'h0;
  endtask

  task automatic irq(input logic r, input logic i, input vec_t v, input level_t l);
    tick(2);
    chk({14'h0, intr, irq_req}, {14'h0, i, r});
    if (r) begin
      chk({5'h0, irq_level, irq_vector}, {5'h0, l, v});
    end
  endtask

  // Take (rt low) or return (rt high), then compare the CPU level
  task automatic cpu(input logic rt, input logic [3:0] lt, input level_t lv);
    int n;
    n = 0;
    @(posedge clk);
    lat    <= lt;
    take   <= !rt;
    ret_go <= rt;
    @(posedge clk);
    take   <= 1'b0;
    ret_go <= 1'b0;
    while (!rt && cpu_ack !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1 n++;
    end
    tick(3);
    chk({12'h0, cpu_level}, {12'h0, lv});
  endtask

  task automatic stop_test();
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_regs();
    bus(0, 8'h00, 16'h0440);
    bus(0, 8'h02, 16'h4444);
    bus(0, 8'h04, 16'h0000);
    bus(0, 8'h12, 16'h0000);
    bus(1, 8'h00, 16'hFFFF);
    bus(0, 8'h00, 16'h0770);
    bus(1, 8'h02, 16'hFFFF);
    bus(0, 8'h02, 16'h7777);
    bus(1, 8'h04, 16'hFFFF);
    bus(0, 8'h04, 16'h0000);
    $display("test regs done");
  endtask

  task automatic t_enable();
    bus(1, 8'h00, 16'h0440);
    bus(1, 8'h02, 16'h4444);
    pulse(6'h01, 4'h0);
    irq(0, 0, 7'h00, 4'h0);
    bus(1, 8'h0C, 16'h003F);
    irq(1, 1, 7'h04, 4'h4);
    bus(0, 8'h04, 16'h0404);
    bus(1, 8'h0A, 16'h003F);
    irq(0, 0, 7'h00, 4'h0);
    $display("test enable done");
  endtask

  // Only source k has a non-zero field, yet every source is pending
  task automatic t_map();
    for (int k = 0; k < 6; k++) begin
      bus(1, 8'h00, (k < 2) ? 16'h0003 << (4 + 4 * k) : 16'h0000);
      bus(1, 8'h02, (k >= 2) ? 16'h0003 << (4 * (k - 2)) : 16'h0000);
      pulse(6'h3F, 4'h0);
      irq(1, 1, vec_t'(4 + k), 4'h3);
      bus(1, 8'h0A, 16'h003F);
    end
    $display("test map done");
  endtask

  task automatic t_tie();
    bus(1, 8'h00, 16'h0550);
    pulse(6'h03, 4'h0);
    irq(1, 1, 7'h04, 4'h5);
    bus(1, 8'h00, 16'h0750);
    irq(1, 1, 7'h05, 4'h7);
    bus(1, 8'h00, 16'h0000);
    irq(0, 1, 7'h00, 4'h0);
    bus(1, 8'h0A, 16'h003F);
    $display("test tie done");
  endtask

  task automatic t_nest();
    bus(1, 8'h00, 16'h0440);
    bus(1, 8'h02, 16'h6444);
    pulse(6'h01, 4'h0);
    irq(1, 1, 7'h04, 4'h4);
    cpu(0, 4'h0, 4'h4);
    irq(0, 1, 7'h00, 4'h0);
    bus(1, 8'h06, 16'h8000);
    pulse(6'h20, 4'h0);
    irq(0, 1, 7'h00, 4'h0);
    bus(1, 8'h06, 16'h0000);
    irq(1, 1, 7'h09, 4'h6);
    cpu(0, 4'h3, 4'h6);
    cpu(1, 4'h0, 4'h4);
    cpu(1, 4'h0, 4'h0);
    irq(1, 1, 7'h09, 4'h6);
    bus(1, 8'h0A, 16'h0020);
    irq(1, 1, 7'h04, 4'h4);
    bus(1, 8'h0A, 16'h0001);
    irq(0, 0, 7'h00, 4'h0);
    $display("test nest done");
  endtask

  task automatic t_mask();
    bus(1, 8'h0E, 16'h000E);
    bus(0, 8'h0E, 16'h000E);
    bus(1, 8'h00, 16'h0070);
    pulse(6'h01, 4'h0);
    irq(0, 1, 7'h00, 4'h0);
    pulse(6'h00, 4'h9);
    irq(1, 1, 7'h03, 4'hE);
    bus(0, 8'h06, 16'h0009);
    bus(1, 8'h06, 16'h0000);
    irq(0, 1, 7'h00, 4'h0);
    bus(1, 8'h0E, 16'h0000);
    irq(1, 1, 7'h04, 4'h7);
    bus(1, 8'h0A, 16'h003F);
    $display("test mask done");
  endtask

  task automatic t_timed();
    bus(1, 8'h00, 16'h0060);
    bus(1, 8'h10, 16'h0028);
    pulse(6'h01, 4'h0);
    irq(0, 1, 7'h00, 4'h0);
    bus(1, 8'h00, 16'h0760);
    pulse(6'h02, 4'h0);
    irq(1, 1, 7'h05, 4'h7);
    bus(1, 8'h0A, 16'h0002);
    tick(40);
    irq(1, 1, 7'h04, 4'h6);
    $display("test timed done");
  endtask

  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    t_regs();
    t_enable();
    t_map();
    t_tie();
    t_nest();
    t_mask();
    t_timed();
    stop_test();
  end
endmodule
